/* File: src/aoc_map.svh */
`ifndef AOC_MAP_SVH
`define AOC_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define AOC_OFS_PORT_SETUP 8'h00
`define AOC_OFS_BURST_LAST 8'h02
`define AOC_OFS_DIE_REV 8'h09
`define AOC_OFS_CONV_SEL 8'h10
`define AOC_OFS_OFS_COARSE 8'h20
`define AOC_OFS_OFS_FINE 8'h21
`define AOC_OFS_GAIN_COARSE 8'h22
`define AOC_OFS_GAIN_MEDIUM 8'h23
`define AOC_OFS_GAIN_FINE 8'h24
`define AOC_OFS_PWR_SEL 8'h25
`define AOC_OFS_OUT_CFG 8'h74
`define AOC_OFS_LOOP_STATUS 8'h75
`define AOC_OFS_TEST_CTRL 8'hC0
`define AOC_OFS_PAT1_LOW 8'hC2
`define AOC_OFS_PAT1_HIGH 8'hC3
`define AOC_OFS_PAT2_LOW 8'hC4
`define AOC_OFS_PAT2_HIGH 8'hC5

// ****************************************
// Field positions
// ****************************************
`define AOC_BIT_DLL_SLOW 6
`define AOC_BIT_DDR 4
`define AOC_BIT_SOFT_RST 5
`define AOC_FLD_MODE_HI 7
`define AOC_FLD_MODE_LO 6
`define AOC_FLD_PAT_HI 3
`define AOC_FLD_PAT_LO 0

// ****************************************
// Reset values
// ****************************************
`define AOC_RST_ZERO 8'h00
`define AOC_RST_CAL 8'h80
`define AOC_RST_STATUS 8'h00
`define AOC_RST_WORD 16'h0000

// ****************************************
// Pattern codes and words
// ****************************************
`define AOC_PAT_OFF 4'h0
`define AOC_PAT_MID 4'h1
`define AOC_PAT_POS 4'h2
`define AOC_PAT_NEG 4'h3
`define AOC_PAT_CHECK 4'h4
`define AOC_PAT_ONEZERO 4'h7
`define AOC_PAT_USER 4'h8
`define AOC_WORD_MID 16'h8000
`define AOC_WORD_ONES 16'hFFFF
`define AOC_WORD_ZEROS 16'h0000
`define AOC_WORD_CHK_A 16'hAAAA
`define AOC_WORD_CHK_B 16'h5555

// ****************************************
// Timing counts
// ****************************************
`define AOC_SETTLE_SAMPLES 4

`endif

/* File: src/aoc_pkg.sv */
package aoc_pkg;
  // Test-mode field of the test control register
  typedef enum logic [1:0] {AOC_STATIC, AOC_ALTERNATE, AOC_MODE_RSV2, AOC_MODE_RSV3} aoc_mode_t;
  // Pattern generator sequencing
  typedef enum logic [1:0] {AOC_GEN_OFF, AOC_GEN_SETTLE, AOC_GEN_RUN} aoc_gen_state_t;
  typedef logic [7:0] aoc_byte_t;
  typedef logic [15:0] aoc_word_t;
endpackage

/* File: src/aoc_pattern_gen.sv */
`timescale 1ns/1ps
`include "aoc_map.svh"

module aoc_pattern_gen #(
  parameter int WIDTH = 16,
  parameter int SETTLE = `AOC_SETTLE_SAMPLES
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Sample side
  input wire logic sample_en_i,
  input wire logic [WIDTH-1:0] conv_data_i,
  // Pattern control
  input wire aoc_pkg::aoc_mode_t test_mode_i,
  input wire logic [3:0] pat_code_i,
  input wire logic [WIDTH-1:0] user_word1_i,
  input wire logic [WIDTH-1:0] user_word2_i,
  // Output bus
  output logic [WIDTH-1:0] data_o,
  output logic pattern_on_o
);
  import aoc_pkg::*;

  aoc_gen_state_t state_r;
  logic [7:0] cnt_r;
  logic phase_r;
  logic [WIDTH-1:0] data_r;

  // ****************************************
  // Pattern decode
  // ****************************************
  // Reserved and unlisted codes behave as off
  wire is_mid = (pat_code_i == `AOC_PAT_MID);
  wire is_pos = (pat_code_i == `AOC_PAT_POS);
  wire is_neg = (pat_code_i == `AOC_PAT_NEG);
  wire is_chk = (pat_code_i == `AOC_PAT_CHECK);
  wire is_onezero = (pat_code_i == `AOC_PAT_ONEZERO);
  wire is_user = (pat_code_i == `AOC_PAT_USER);
  wire code_valid = is_mid | is_pos | is_neg | is_chk | is_onezero | is_user; // RULE_09 RULE_10
  wire [WIDTH-1:0] word1 = is_mid ? WIDTH'(`AOC_WORD_MID) : // RULE_09
                           is_pos ? WIDTH'(`AOC_WORD_ONES) :
                           is_chk ? WIDTH'(`AOC_WORD_CHK_A) : // RULE_10
                           is_onezero ? WIDTH'(`AOC_WORD_ONES) :
                           is_user ? user_word1_i : // RULE_11
                           WIDTH'(`AOC_WORD_ZEROS);
  // Single-word patterns repeat word 1 in alternate mode
  wire [WIDTH-1:0] word2 = is_chk ? WIDTH'(`AOC_WORD_CHK_B) : // RULE_10
                           is_onezero ? WIDTH'(`AOC_WORD_ZEROS) :
                           is_user ? user_word2_i : // RULE_11
                           word1;
  wire alt_mode = (test_mode_i == AOC_ALTERNATE); // RULE_05
  wire [WIDTH-1:0] pat_word = (alt_mode && phase_r) ? word2 : word1; // RULE_06 RULE_07
  wire settle_done = (cnt_r >= 8'(SETTLE - 1));

  // ****************************************
  // Entry sequencing
  // ****************************************
  // Entry is counted in samples so the bus never shows a half-applied pattern
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_r <= AOC_GEN_OFF;
      cnt_r <= 8'h00;
    end
    else if (!code_valid)
    begin
      state_r <= AOC_GEN_OFF;
      cnt_r <= 8'h00;
    end
    else
    begin
      unique case (state_r)
        AOC_GEN_OFF:
          state_r <= AOC_GEN_SETTLE;
        AOC_GEN_SETTLE:
          if (sample_en_i)
          begin
            cnt_r <= cnt_r + 8'h01;
            if (settle_done)
              state_r <= AOC_GEN_RUN; // RULE_08
          end
        AOC_GEN_RUN:
          cnt_r <= 8'h00;
        default:
          state_r <= AOC_GEN_OFF;
      endcase
    end
  end

  assign pattern_on_o = (state_r == AOC_GEN_RUN);

  // Phase and data move only on sample strobes
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      phase_r <= 1'b0;
      data_r <= WIDTH'(`AOC_WORD_ZEROS);
    end
    else if (sample_en_i)
    begin
      phase_r <= pattern_on_o ? ~phase_r : 1'b0; // RULE_07
      data_r <= pattern_on_o ? pat_word : conv_data_i; // RULE_15
    end
  end

  assign data_o = data_r;

  // ****************************************
  // Checks
  // ****************************************
  property p_pass_through;
    @(posedge core_clk_i) disable iff (rst_i)
    (sample_en_i && !pattern_on_o) |=> (data_o == $past(conv_data_i));
  endproperty
  a_pass_through: assert property (p_pass_through) else $error("conversion data not passed"); // RULE_15

  property p_entry_latency;
    @(posedge core_clk_i) disable iff (rst_i)
    (!code_valid ##1 code_valid) |-> !pattern_on_o ##1 !pattern_on_o;
  endproperty
  a_entry_latency: assert property (p_entry_latency) else $error("pattern applied too early"); // RULE_08

  property p_static_word;
    @(posedge core_clk_i) disable iff (rst_i)
    (sample_en_i && pattern_on_o && !alt_mode) |=> (data_o == $past(word1));
  endproperty
  a_static_word: assert property (p_static_word) else $error("static word not held"); // RULE_06

  property p_checker_alt;
    @(posedge core_clk_i) disable iff (rst_i)
    (sample_en_i && pattern_on_o && alt_mode && is_chk)
      |=> (data_o == ($past(phase_r) ? WIDTH'(`AOC_WORD_CHK_B) : WIDTH'(`AOC_WORD_CHK_A)));
  endproperty
  a_checker_alt: assert property (p_checker_alt) else $error("checkerboard words wrong"); // RULE_10

  property p_midscale;
    @(posedge core_clk_i) disable iff (rst_i)
    (sample_en_i && pattern_on_o && is_mid) |=> (data_o == WIDTH'(`AOC_WORD_MID));
  endproperty
  a_midscale: assert property (p_midscale) else $error("midscale word wrong"); // RULE_09

  c_alt_run: cover property (@(posedge core_clk_i) disable iff (rst_i)
    pattern_on_o && alt_mode && sample_en_i ##[1:8] sample_en_i);
  c_user_run: cover property (@(posedge core_clk_i) disable iff (rst_i) pattern_on_o && is_user);
endmodule

/* File: src/aoc_top.sv */
`timescale 1ns/1ps
`include "aoc_map.svh"

// Summary of operation
// RULE_01: Output configuration bit 6 picks loop range, fast when clear, slow when set.
// RULE_02: Output configuration bit 4 set selects double data rate, clear selects single.
// RULE_03: Host picks slow range for 40-100 MSPS, fast for 80 MSPS upward.
// RULE_04: Host writes configuration XOR status XOR desired value to change loop settings.
// RULE_05: Test control bits 7:6 pick static (0) or alternating (1) mode.
// RULE_06: Static mode holds one fixed word on the output bus.
// RULE_07: Alternating mode drives word one and word two on successive phases.
// RULE_08: Pattern appears several samples after entry; receivers tolerate that latency.
// RULE_09: Pattern codes: 0 off, 1 midscale, 2 positive full, 3 negative full.
// RULE_10: Code 4 checkerboard AAAA/5555, code 7 ones/zeros, codes 5 and 6 reserved.
// RULE_11: Code 8 sources both words from the user pattern byte registers.
// RULE_12: First user word is built from a low and a high byte register.
// RULE_13: Second user word is built from its own low and high byte registers.
// RULE_14: Output configuration resets to zero and ignores soft reset.
// RULE_15: With pattern off, conversion results pass straight to the outputs.
// RULE_16: Second user word bytes sit at 0xC4 and 0xC5.

module aoc_top #(
  parameter int WIDTH = 16,
  parameter int SETTLE = `AOC_SETTLE_SAMPLES,
  parameter logic [7:0] CAL_DEFAULT = `AOC_RST_CAL,
  parameter logic [7:0] STATUS_INIT = `AOC_RST_STATUS,
  parameter logic [7:0] DIE_REVISION = 8'h01 // Arbitrary value
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Register access port
  input wire logic [7:0] reg_addr_i,
  input wire aoc_pkg::aoc_byte_t reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output aoc_pkg::aoc_byte_t reg_rdata_o,
  output logic reg_rvalid_o,
  // Sample side
  input wire logic sample_en_i,
  input wire logic [WIDTH-1:0] conv_data_i,
  // Output side
  output logic [WIDTH-1:0] out_data_o,
  output logic pattern_on_o,
  output logic dll_slow_o,
  output logic ddr_mode_o,
  // Settings for neighbouring blocks
  output logic [2:0] power_down_sel_o,
  output logic [1:0] converter_sel_o
);
  import aoc_pkg::*;

  aoc_byte_t port_setup_r;
  aoc_byte_t burst_last_r;
  aoc_byte_t conv_sel_r;
  aoc_byte_t ofs_coarse_r;
  aoc_byte_t ofs_fine_r;
  aoc_byte_t gain_coarse_r;
  aoc_byte_t gain_medium_r;
  aoc_byte_t gain_fine_r;
  aoc_byte_t pwr_sel_r;
  aoc_byte_t out_cfg_r;
  aoc_byte_t loop_status_r;
  aoc_byte_t test_ctrl_r;
  aoc_byte_t pat1_low_r;
  aoc_byte_t pat1_high_r;
  aoc_byte_t pat2_low_r;
  aoc_byte_t pat2_high_r;
  aoc_byte_t rdata_r;
  aoc_byte_t rdata_nxt;
  logic rvalid_r;

  // ****************************************
  // Write decode
  // ****************************************
  wire wr_port = reg_wr_i && (reg_addr_i == `AOC_OFS_PORT_SETUP);
  wire wr_burst = reg_wr_i && (reg_addr_i == `AOC_OFS_BURST_LAST);
  wire wr_conv = reg_wr_i && (reg_addr_i == `AOC_OFS_CONV_SEL);
  wire wr_ofs_c = reg_wr_i && (reg_addr_i == `AOC_OFS_OFS_COARSE);
  wire wr_ofs_f = reg_wr_i && (reg_addr_i == `AOC_OFS_OFS_FINE);
  wire wr_gain_c = reg_wr_i && (reg_addr_i == `AOC_OFS_GAIN_COARSE);
  wire wr_gain_m = reg_wr_i && (reg_addr_i == `AOC_OFS_GAIN_MEDIUM);
  wire wr_gain_f = reg_wr_i && (reg_addr_i == `AOC_OFS_GAIN_FINE);
  wire wr_pwr = reg_wr_i && (reg_addr_i == `AOC_OFS_PWR_SEL);
  wire wr_out_cfg = reg_wr_i && (reg_addr_i == `AOC_OFS_OUT_CFG);
  wire wr_test = reg_wr_i && (reg_addr_i == `AOC_OFS_TEST_CTRL);
  wire wr_p1_lo = reg_wr_i && (reg_addr_i == `AOC_OFS_PAT1_LOW);
  wire wr_p1_hi = reg_wr_i && (reg_addr_i == `AOC_OFS_PAT1_HIGH);
  wire wr_p2_lo = reg_wr_i && (reg_addr_i == `AOC_OFS_PAT2_LOW); // RULE_16
  wire wr_p2_hi = reg_wr_i && (reg_addr_i == `AOC_OFS_PAT2_HIGH); // RULE_16
  // Soft reset is a pulse; the bit itself never stays set
  wire soft_rst = wr_port && reg_wdata_i[`AOC_BIT_SOFT_RST];

  // ****************************************
  // Port setup and indexed trims
  // ****************************************
  // Trims return to their reset values on soft reset: gain coarse to zero, the others to calibration default
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      port_setup_r <= `AOC_RST_ZERO;
      burst_last_r <= `AOC_RST_ZERO;
      conv_sel_r <= `AOC_RST_ZERO;
      ofs_coarse_r <= CAL_DEFAULT;
      ofs_fine_r <= CAL_DEFAULT;
      gain_coarse_r <= `AOC_RST_ZERO;
      gain_medium_r <= CAL_DEFAULT;
      gain_fine_r <= CAL_DEFAULT;
    end
    else if (soft_rst)
    begin
      port_setup_r <= `AOC_RST_ZERO;
      burst_last_r <= `AOC_RST_ZERO;
      conv_sel_r <= `AOC_RST_ZERO;
      ofs_coarse_r <= CAL_DEFAULT;
      ofs_fine_r <= CAL_DEFAULT;
      gain_coarse_r <= `AOC_RST_ZERO;
      gain_medium_r <= CAL_DEFAULT;
      gain_fine_r <= CAL_DEFAULT;
    end
    else
    begin
      if (wr_port)
        port_setup_r <= reg_wdata_i;
      if (wr_burst)
        burst_last_r <= reg_wdata_i;
      if (wr_conv)
        conv_sel_r <= reg_wdata_i;
      if (wr_ofs_c)
        ofs_coarse_r <= reg_wdata_i;
      if (wr_ofs_f)
        ofs_fine_r <= reg_wdata_i;
      if (wr_gain_c)
        gain_coarse_r <= reg_wdata_i;
      if (wr_gain_m)
        gain_medium_r <= reg_wdata_i;
      if (wr_gain_f)
        gain_fine_r <= reg_wdata_i;
    end
  end

  // ****************************************
  // Soft-reset-proof settings
  // ****************************************
  // Only the hard reset touches these
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pwr_sel_r <= `AOC_RST_ZERO;
      out_cfg_r <= `AOC_RST_ZERO; // RULE_14
      loop_status_r <= STATUS_INIT;
    end
    else
    begin
      if (wr_pwr)
        pwr_sel_r <= reg_wdata_i;
      if (wr_out_cfg)
        out_cfg_r <= reg_wdata_i; // RULE_14
      // Status keeps the setting in force before the write, so a write toggles it
      if (wr_out_cfg)
        loop_status_r <= out_cfg_r ^ loop_status_r; // RULE_04
    end
  end

  // Effective loop settings are the stored byte folded with status;
  // a plain write therefore only lands if the host used the XOR procedure
  wire [7:0] out_cfg_eff = out_cfg_r ^ loop_status_r; // RULE_04
  assign dll_slow_o = out_cfg_eff[`AOC_BIT_DLL_SLOW]; // RULE_01
  assign ddr_mode_o = out_cfg_eff[`AOC_BIT_DDR]; // RULE_02
  assign power_down_sel_o = pwr_sel_r[2:0];
  assign converter_sel_o = conv_sel_r[1:0];

  // ****************************************
  // Test pattern registers
  // ****************************************
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      test_ctrl_r <= `AOC_RST_ZERO;
      pat1_low_r <= `AOC_RST_ZERO;
      pat1_high_r <= `AOC_RST_ZERO;
      pat2_low_r <= `AOC_RST_ZERO;
      pat2_high_r <= `AOC_RST_ZERO;
    end
    else if (soft_rst)
    begin
      test_ctrl_r <= `AOC_RST_ZERO;
      pat1_low_r <= `AOC_RST_ZERO;
      pat1_high_r <= `AOC_RST_ZERO;
      pat2_low_r <= `AOC_RST_ZERO;
      pat2_high_r <= `AOC_RST_ZERO;
    end
    else
    begin
      if (wr_test)
        test_ctrl_r <= reg_wdata_i;
      if (wr_p1_lo)
        pat1_low_r <= reg_wdata_i;
      if (wr_p1_hi)
        pat1_high_r <= reg_wdata_i;
      if (wr_p2_lo)
        pat2_low_r <= reg_wdata_i;
      if (wr_p2_hi)
        pat2_high_r <= reg_wdata_i;
    end
  end

  // Assemble the user words from their byte pairs
  wire [15:0] first_custom_word = {pat1_high_r, pat1_low_r}; // RULE_12
  wire [15:0] second_custom_word = {pat2_high_r, pat2_low_r}; // RULE_13
  wire aoc_mode_t test_mode = aoc_mode_t'(test_ctrl_r[`AOC_FLD_MODE_HI:`AOC_FLD_MODE_LO]); // RULE_05
  wire [3:0] pat_code = test_ctrl_r[`AOC_FLD_PAT_HI:`AOC_FLD_PAT_LO]; // RULE_09

  // ****************************************
  // Read path
  // ****************************************
  // Unmapped and reserved offsets read as zero
  always_comb
  begin
    unique case (reg_addr_i)
      `AOC_OFS_PORT_SETUP: rdata_nxt = port_setup_r;
      `AOC_OFS_BURST_LAST: rdata_nxt = burst_last_r;
      `AOC_OFS_DIE_REV: rdata_nxt = DIE_REVISION;
      `AOC_OFS_CONV_SEL: rdata_nxt = conv_sel_r;
      `AOC_OFS_OFS_COARSE: rdata_nxt = ofs_coarse_r;
      `AOC_OFS_OFS_FINE: rdata_nxt = ofs_fine_r;
      `AOC_OFS_GAIN_COARSE: rdata_nxt = gain_coarse_r;
      `AOC_OFS_GAIN_MEDIUM: rdata_nxt = gain_medium_r;
      `AOC_OFS_GAIN_FINE: rdata_nxt = gain_fine_r;
      `AOC_OFS_PWR_SEL: rdata_nxt = pwr_sel_r;
      `AOC_OFS_OUT_CFG: rdata_nxt = out_cfg_r;
      `AOC_OFS_LOOP_STATUS: rdata_nxt = loop_status_r; // RULE_04
      `AOC_OFS_TEST_CTRL: rdata_nxt = test_ctrl_r;
      `AOC_OFS_PAT1_LOW: rdata_nxt = pat1_low_r;
      `AOC_OFS_PAT1_HIGH: rdata_nxt = pat1_high_r;
      `AOC_OFS_PAT2_LOW: rdata_nxt = pat2_low_r;
      `AOC_OFS_PAT2_HIGH: rdata_nxt = pat2_high_r;
      default: rdata_nxt = `AOC_RST_ZERO;
    endcase
  end

  // Read data is registered, one cycle after the strobe
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rdata_r <= `AOC_RST_ZERO;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rvalid_r <= reg_rd_i;
      if (reg_rd_i)
        rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign reg_rvalid_o = rvalid_r;

  // ****************************************
  // Output pattern generator
  // ****************************************
  aoc_pattern_gen #(
    .WIDTH(WIDTH),
    .SETTLE(SETTLE)
  ) u_gen (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .sample_en_i(sample_en_i),
    .conv_data_i(conv_data_i),
    .test_mode_i(test_mode),
    .pat_code_i(pat_code),
    .user_word1_i(WIDTH'(first_custom_word)), // RULE_11
    .user_word2_i(WIDTH'(second_custom_word)),
    .data_o(out_data_o),
    .pattern_on_o(pattern_on_o)
  );

  // ****************************************
  // Checks
  // ****************************************
  property p_dll_range;
    @(posedge core_clk_i) disable iff (rst_i)
    wr_out_cfg |=> (dll_slow_o == ($past(reg_wdata_i[`AOC_BIT_DLL_SLOW]) ^ $past(out_cfg_eff[`AOC_BIT_DLL_SLOW])));
  endproperty
  a_dll_range: assert property (p_dll_range) else $error("loop range not taken"); // RULE_01

  property p_ddr_mode;
    @(posedge core_clk_i) disable iff (rst_i)
    wr_out_cfg |=> (ddr_mode_o == ($past(reg_wdata_i[`AOC_BIT_DDR]) ^ $past(out_cfg_eff[`AOC_BIT_DDR])));
  endproperty
  a_ddr_mode: assert property (p_ddr_mode) else $error("data rate not taken"); // RULE_02

  property p_soft_keep;
    @(posedge core_clk_i) disable iff (rst_i)
    soft_rst |=> (out_cfg_r == $past(out_cfg_r)) && (pwr_sel_r == $past(pwr_sel_r));
  endproperty
  a_soft_keep: assert property (p_soft_keep) else $error("soft reset changed kept setting"); // RULE_14

  property p_status_read;
    @(posedge core_clk_i) disable iff (rst_i)
    (reg_rd_i && reg_addr_i == `AOC_OFS_LOOP_STATUS) |=> reg_rvalid_o && (reg_rdata_o == $past(loop_status_r));
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong"); // RULE_04

  property p_word1_bytes;
    @(posedge core_clk_i) disable iff (rst_i)
    wr_p1_hi |=> (first_custom_word == {$past(reg_wdata_i), $past(pat1_low_r)});
  endproperty
  a_word1_bytes: assert property (p_word1_bytes) else $error("first user word wrong"); // RULE_12

  property p_word2_bytes;
    @(posedge core_clk_i) disable iff (rst_i)
    wr_p2_hi |=> (second_custom_word == {$past(reg_wdata_i), $past(pat2_low_r)});
  endproperty
  a_word2_bytes: assert property (p_word2_bytes) else $error("second user word wrong"); // RULE_13 RULE_16

  property p_mode_decode;
    @(posedge core_clk_i) disable iff (rst_i)
    (wr_test && !soft_rst) |=> (test_mode == aoc_mode_t'($past(reg_wdata_i[7:6]))) && (pat_code == $past(reg_wdata_i[3:0]));
  endproperty
  a_mode_decode: assert property (p_mode_decode) else $error("test control decode wrong"); // RULE_05

  c_out_cfg_write: cover property (@(posedge core_clk_i) disable iff (rst_i) wr_out_cfg ##1 ddr_mode_o);
  c_soft_reset: cover property (@(posedge core_clk_i) disable iff (rst_i) soft_rst);
  c_pattern_on: cover property (@(posedge core_clk_i) disable iff (rst_i) $rose(pattern_on_o));
endmodule

/* File: verification/aoc_host_model.sv */
`timescale 1ns/1ps
`include "aoc_map.svh"

module aoc_host_model
(
  // Clock
  input wire logic core_clk_i,
  // Register port towards the device
  output logic [7:0] reg_addr_o,
  output aoc_pkg::aoc_byte_t reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire aoc_pkg::aoc_byte_t reg_rdata_i,
  input wire logic reg_rvalid_i,
  // Reads that got no answer
  output int miss_o
);
  import aoc_pkg::*;

  // Idle levels at time zero
  initial
  begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    miss_o = 0;
  end

  // One-cycle write strobe, data scrambled after release
  task automatic wr(input logic [7:0] a, input aoc_byte_t d);
    @(posedge core_clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_o <= 1'b0;
    reg_wdata_o <= ~d; // Released bus must not look valid
    #1;
  endtask

  // One-cycle read strobe, answer taken the cycle after
  task automatic rd(input logic [7:0] a, output aoc_byte_t d);
    @(posedge core_clk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_o <= 1'b0;
    #1;
    d = reg_rdata_i;
    if (reg_rvalid_i !== 1'b1)
      miss_o++;
  endtask

  // Loop range and rate change; slow range meant for 40-100 MSPS only
  task automatic loop_set(input aoc_byte_t want);
    aoc_byte_t c;
    aoc_byte_t s;
    rd(`AOC_OFS_OUT_CFG, c);
    rd(`AOC_OFS_LOOP_STATUS, s);
    wr(`AOC_OFS_OUT_CFG, c ^ s ^ want);
  endtask
endmodule

/* File: verification/adc_output_config_and_test_pattern_bench.sv */
`timescale 1ns/1ps
`include "aoc_map.svh"

// ****************************************
// Compare helper
// ****************************************
`define CHK(n, e, g) \
  begin \
    num_checks++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("ERROR %s expected %h seen %h", n, e, g); \
    end \
  end

module adc_output_config_and_test_pattern_bench;
  import aoc_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sample_en_i = 1'b0;
  logic [15:0] conv_data_i = 16'h0000;
  logic [7:0] reg_addr;
  aoc_byte_t reg_wdata, reg_rdata, rb;
  logic reg_wr, reg_rd, reg_rvalid, pattern_on_o, dll_slow_o, ddr_mode_o;
  logic [15:0] out_data_o;
  logic [2:0] power_down_sel_o;
  logic [1:0] converter_sel_o;
  int miss;
  int error_cnt = 0;
  int num_checks = 0;
  logic [7:0] rst_adr [13] = '{8'h00, 8'h02, 8'h09, 8'h10, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h74, 8'h75, 8'h30};
  logic [7:0] rst_val [13] = '{8'h00, 8'h00, 8'h3C, 8'h00, 8'h80, 8'h80, 8'h00, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] ctl [7] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h44, 8'h47, 8'h48};
  logic [15:0] w1 [7] = '{16'h8000, 16'hFFFF, 16'h0000, 16'hAAAA, 16'hAAAA, 16'hFFFF, 16'h1234};
  logic [15:0] w2 [7] = '{16'h8000, 16'hFFFF, 16'h0000, 16'hAAAA, 16'h5555, 16'h0000, 16'hABCD};

  // 50 MHz clock
  always #10 core_clk_i = ~core_clk_i;

  aoc_host_model host (.core_clk_i(core_clk_i), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
    .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata), .reg_rvalid_i(reg_rvalid), .miss_o(miss));

  // Short entry latency keeps the run brief; die revision value is arbitrary
  aoc_top #(.SETTLE(1), .DIE_REVISION(8'h3C)) DUT (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rvalid), .sample_en_i(sample_en_i),
    .conv_data_i(conv_data_i), .out_data_o(out_data_o), .pattern_on_o(pattern_on_o),
    .dll_slow_o(dll_slow_o), .ddr_mode_o(ddr_mode_o), .power_down_sel_o(power_down_sel_o),
    .converter_sel_o(converter_sel_o));

  // One sample strobe, output settled afterwards
  task automatic strobe(input logic [15:0] cv);
    @(posedge core_clk_i);
    sample_en_i <= 1'b1;
    conv_data_i <= cv;
    @(posedge core_clk_i);
    sample_en_i <= 1'b0;
    #1;
  endtask

  task automatic samp(input logic [15:0] cv, input logic [15:0] exp);
    strobe(cv);
    `CHK("out_data_o", exp, out_data_o)
  endtask

  task automatic rchk(input logic [7:0] a, input aoc_byte_t exp);
    host.rd(a, rb);
    `CHK("reg_rdata_o", exp, rb)
  endtask

  // Enter a pattern, tolerating a bounded number of entry samples
  task automatic enter(input aoc_byte_t c);
    host.wr(`AOC_OFS_TEST_CTRL, c);
    for (int i = 0; i < 8 && pattern_on_o !== 1'b1; i++)
      strobe(16'h0F0F);
    `CHK("pattern_on_o", 1'b1, pattern_on_o)
  endtask

  task automatic tally_and_finish;
    error_cnt += miss;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    foreach (rst_adr[i]) rchk(rst_adr[i], rst_val[i]);
    host.wr(8'h09, 8'hFF);
    rchk(8'h09, 8'h3C);
    host.wr(8'h02, 8'h5A);
    host.wr(8'h25, 8'h04);
    host.wr(8'h10, 8'h02);
    host.loop_set(8'h50);
    `CHK("dll_slow_o", 1'b1, dll_slow_o)
    `CHK("ddr_mode_o", 1'b1, ddr_mode_o)
    `CHK("converter_sel_o", 2'h2, converter_sel_o)
    host.wr(8'h00, 8'h20);
    rchk(8'h02, 8'h00);
    `CHK("power_down_sel_o", 3'h4, power_down_sel_o)
    `CHK("dll_slow_o", 1'b1, dll_slow_o)
    host.loop_set(8'h10);
    `CHK("dll_slow_o", 1'b0, dll_slow_o)
    `CHK("ddr_mode_o", 1'b1, ddr_mode_o)
    host.wr(8'hC2, 8'h34);
    host.wr(8'hC3, 8'h12);
    host.wr(8'hC4, 8'hCD);
    host.wr(8'hC5, 8'hAB);
    rchk(8'hC4, 8'hCD);
    samp(16'h3A5C, 16'h3A5C);
    foreach (ctl[i])
    begin
      enter(ctl[i]);
      samp(16'h3A5C, w1[i]);
      samp(16'h3A5C, w2[i]);
      samp(16'h3A5C, w1[i]);
      host.wr(`AOC_OFS_TEST_CTRL, 8'h00);
      samp(16'hC3A5, 16'hC3A5);
    end
    host.wr(`AOC_OFS_TEST_CTRL, 8'h45);
    repeat (3) strobe(16'h1111);
    samp(16'h2468, 16'h2468);
    tally_and_finish;
  end

  // Watchdog
  initial
  begin
    #400000;
    error_cnt++;
    tally_and_finish;
  end
endmodule
